// ==== shared/mcs_pkg.sv ====
/*
  Package for the multislope conversion sequencer: phase lengths, counter widths,
  switch-control and result structs, sequencer states.
  Assumes one system clock; the oscillator is modelled as a clock-enable input.
*/
package mcs_pkg;
  localparam int unsigned OSC_DIVIDE = 4;
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam int unsigned CONV_CYCLES = 1280;
  localparam int unsigned ZERO_CYCLES = 246;
  localparam int unsigned INTEG_CYCLES = 256;
  localparam int unsigned FAST_MAX = 512;
  localparam int unsigned SLOW_MAX = 64;
  localparam int unsigned OVR_MAX = 64;
  localparam int unsigned OVR_PHASES = 3;
  localparam int unsigned SETTLE_CYCLES = 10;
  localparam int unsigned DEINT_CYCLES = 778;
  localparam int unsigned BUSY_CYCLES = 836;
  localparam int unsigned OVR_LIMIT = 192;
  localparam int unsigned FAST_BITS = 9;
  localparam int unsigned SLOW_BITS = 6;
  localparam int unsigned MAG_BITS = 15;
  localparam int unsigned CNT_BITS = 11;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ZERO = 3'b001,
    ST_INTEG = 3'b010,
    ST_SETTLE = 3'b011,
    ST_FAST = 3'b100,
    ST_SLOW = 3'b101,
    ST_OVR = 3'b110,
    ST_TAIL = 3'b111
  } mcs_state_e;

  // analog switch network controls, one bit per switch group
  typedef struct packed {
    logic input_connect;
    logic short_to_common;
    logic autozero_loop;
    logic neg_to_common;
    logic fast_reference_capacitor;
    logic slow_reference_capacitor;
    logic reference_negative;
  } mcs_switch_s;

  typedef struct packed {
    logic positive;
    logic overrange;
    logic [MAG_BITS-1:0] magnitude;
  } mcs_result_s;
endpackage : mcs_pkg

// ==== hw/mcs_sequencer.sv ====
/*
  Multislope integrating converter sequencer: divider, phase sequencing,
  switch control, fast/slow/overrange counting, result latch and busy flag.
  Assumes the analog network outside; comparator is synchronous, equal to the
  polarity sampled at integrate end while integrator charge remains.
*/
// Function
// - each conversion runs zero, integrate, de-integrate in fixed order
// - whole conversion lasts exactly 1280 divided clocks
// - zeroing phase lasts 246 divided clocks
// - zeroing opens inputs, shorts nodes to common, closes auto-zero loop
// - integrate opens loop, connects inputs, lasts 256 divided clocks
// - counter clock is oscillator divided by four
// - de-integrate runs fast, then slow, then overrange subphases
// - fast: negative node to common, positive to fast capacitor, max 512
// - slow: positive node to slow capacitor, max 64 clocks
// - always three overrange subphases, each 64 clocks long
// - overrange converts up to 192 counts beyond full scale
// - de-integrate includes 10 settle clocks, totals 778 clocks
// - counters measure discharge time, proportional to input
// - negative input returns to common in zeroing and de-integrate
// - two counter sets, sequencer, divider, result latches present
// - busy rises at de-integrate start, high 836 clocks, data valid on fall
// - demand mode: select plus low strobe starts one; continuous repeats
`timescale 1ns/1ns
module mcs_sequencer (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // oscillator input, one-cycle enable per oscillator period
  input wire logic OSC_TICK_IN,
  // mode and start
  input wire logic CONVERSION_MODE_SELECT_IN,
  input wire logic SELECT_IN,
  input wire logic START_N_IN,
  // comparator from the integrator
  input wire logic COMPARATOR_IN,
  // switch network
  output mcs_pkg::mcs_switch_s SWITCH_OUT,
  // result
  output mcs_pkg::mcs_result_s RESULT_OUT,
  output logic BUSY_OUT,
  output logic PHASE_TICK_OUT
);
  import mcs_pkg::*;

  // divider: internal clock is oscillator / 4
  logic [1:0] div, next_div;
  logic tick;
  always_comb begin
    next_div = div;
    if (OSC_TICK_IN) begin
      next_div = div + 2'h1;
    end
  end
  assign tick = OSC_TICK_IN && (div == DIV_LAST);
  assign PHASE_TICK_OUT = tick;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div <= 2'h0;
    end else begin
      div <= next_div;
    end
  end

  // demand strobe: START_N_IN falling edge while selected, held until a conversion starts
  logic start_prev, next_start_prev, pending, next_pending;
  logic strobe;
  assign strobe = SELECT_IN && !START_N_IN && start_prev;

  // sequencer state, phase counter, the two counter sets
  mcs_state_e state, next_state;
  logic [CNT_BITS-1:0] phase_cnt, next_phase_cnt;
  logic [CNT_BITS-1:0] deint_cnt, next_deint_cnt;
  logic [FAST_BITS-1:0] fast_cnt, next_fast_cnt;
  logic [SLOW_BITS-1:0] slow_cnt, next_slow_cnt;
  logic [7:0] ovr_cnt, next_ovr_cnt;
  logic [1:0] ovr_idx, next_ovr_idx;
  logic positive, next_positive;
  logic crossed, next_crossed;
  mcs_result_s result, next_result;
  logic busy, next_busy;

  function automatic logic last(input logic [CNT_BITS-1:0] cnt, input int unsigned len);
    last = (cnt == CNT_BITS'(len - 1));
  endfunction : last

  always_comb begin
    next_state = state;
    next_phase_cnt = phase_cnt;
    next_deint_cnt = deint_cnt;
    next_fast_cnt = fast_cnt;
    next_slow_cnt = slow_cnt;
    next_ovr_cnt = ovr_cnt;
    next_ovr_idx = ovr_idx;
    next_positive = positive;
    next_crossed = crossed;
    next_result = result;
    next_busy = busy;
    next_start_prev = START_N_IN;
    next_pending = pending || strobe;
    if (tick) begin
      next_phase_cnt = phase_cnt + CNT_BITS'(1);
      // busy has its own count: it outlasts the 778-tick reference phase and
      // may end inside the next zeroing phase when converting continuously
      if (busy) begin
        next_deint_cnt = deint_cnt + CNT_BITS'(1);
        if (last(deint_cnt, BUSY_CYCLES)) begin
          next_busy = 1'b0;
          next_result.positive = positive;
          next_result.overrange = (ovr_cnt != 8'h00);
          next_result.magnitude = {fast_cnt, slow_cnt} + MAG_BITS'(ovr_cnt);
        end
      end
      case (state)
        ST_IDLE: begin
          if (CONVERSION_MODE_SELECT_IN || pending) begin
            next_pending = strobe;
            next_state = ST_ZERO;
            next_phase_cnt = '0;
          end
        end
        ST_ZERO: begin
          if (last(phase_cnt, ZERO_CYCLES)) begin
            next_state = ST_INTEG;
            next_phase_cnt = '0;
          end
        end
        ST_INTEG: begin
          if (last(phase_cnt, INTEG_CYCLES)) begin
            next_positive = COMPARATOR_IN;
            next_state = ST_SETTLE;
            next_phase_cnt = '0;
            next_deint_cnt = '0;
            next_fast_cnt = '0;
            next_slow_cnt = '0;
            next_ovr_cnt = '0;
            next_ovr_idx = '0;
            next_crossed = 1'b0;
            next_busy = 1'b1;
          end
        end
        ST_SETTLE: begin
          if (last(phase_cnt, SETTLE_CYCLES)) begin
            next_state = ST_FAST;
            next_phase_cnt = '0;
          end
        end
        ST_FAST: begin
          // count while comparator matches the sampled polarity; no crossed latch in fast
          if (COMPARATOR_IN == positive) begin
            next_fast_cnt = fast_cnt + FAST_BITS'(1);
          end
          if (last(phase_cnt, FAST_MAX)) begin
            next_state = ST_SLOW;
            next_phase_cnt = '0;
          end
        end
        ST_SLOW: begin
          if (COMPARATOR_IN == positive && !crossed) begin
            next_slow_cnt = slow_cnt + SLOW_BITS'(1);
          end else begin
            next_crossed = 1'b1;
          end
          if (last(phase_cnt, SLOW_MAX)) begin
            next_state = ST_OVR;
            next_phase_cnt = '0;
          end
        end
        ST_OVR: begin
          if (COMPARATOR_IN == positive && !crossed && ovr_cnt < 8'(OVR_LIMIT)) begin
            next_ovr_cnt = ovr_cnt + 8'h01;
          end else begin
            next_crossed = 1'b1;
          end
          if (last(phase_cnt, OVR_MAX)) begin
            next_phase_cnt = '0;
            next_ovr_idx = ovr_idx + 2'h1;
            if (ovr_idx == 2'(OVR_PHASES - 1)) begin
              // reference phase closes after 778 ticks; a queued or continuous
              // start follows at once so a cycle stays exactly 1280 ticks
              next_state = ST_IDLE;
              if (CONVERSION_MODE_SELECT_IN || pending) begin
                next_pending = strobe;
                next_state = ST_ZERO;
              end
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= ST_IDLE;
      phase_cnt <= '0;
      deint_cnt <= '0;
      fast_cnt <= '0;
      slow_cnt <= '0;
      ovr_cnt <= 8'h00;
      ovr_idx <= 2'h0;
      positive <= 1'b0;
      crossed <= 1'b0;
      result <= '0;
      busy <= 1'b0;
      start_prev <= 1'b1;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      phase_cnt <= next_phase_cnt;
      deint_cnt <= next_deint_cnt;
      fast_cnt <= next_fast_cnt;
      slow_cnt <= next_slow_cnt;
      ovr_cnt <= next_ovr_cnt;
      ovr_idx <= next_ovr_idx;
      positive <= next_positive;
      crossed <= next_crossed;
      result <= next_result;
      busy <= next_busy;
      start_prev <= next_start_prev;
      pending <= next_pending;
    end
  end

  // switch network decode from state; reference polarity from the sampled sign
  always_comb begin
    SWITCH_OUT = '0;
    SWITCH_OUT.reference_negative = !positive;
    case (state)
      ST_ZERO: begin
        SWITCH_OUT.short_to_common = 1'b1;
        SWITCH_OUT.autozero_loop = 1'b1;
        SWITCH_OUT.neg_to_common = 1'b1;
      end
      ST_INTEG: SWITCH_OUT.input_connect = 1'b1;
      // settling: no reference connected, so no charge leaves uncounted
      ST_SETTLE: SWITCH_OUT.neg_to_common = 1'b1;
      ST_FAST: begin
        SWITCH_OUT.neg_to_common = 1'b1;
        SWITCH_OUT.fast_reference_capacitor = 1'b1;
      end
      ST_SLOW, ST_OVR, ST_TAIL: begin
        SWITCH_OUT.neg_to_common = 1'b1;
        SWITCH_OUT.slow_reference_capacitor = 1'b1;
      end
      default: SWITCH_OUT.short_to_common = 1'b1;
    endcase
  end

  assign RESULT_OUT = result;
  assign BUSY_OUT = busy;
endmodule : mcs_sequencer

// ==== verif/mcs_chk.sv ====
/* checker for the sequencer ports, bound at the foot.
   assumes OSC_TICK_IN enables at most every clock. */
`timescale 1ns/1ns
module mcs_chk (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // outputs watched
  input mcs_pkg::mcs_switch_s SWITCH_OUT,
  input mcs_pkg::mcs_result_s RESULT_OUT,
  input wire logic BUSY_OUT,
  input wire logic PHASE_TICK_OUT
);
  import mcs_pkg::*;
  logic [9:0] zc, ic, bc, next_zc, next_ic, next_bc;
  logic [10:0] cc, next_cc;
  logic az_q;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // tick counts per phase, cleared outside it
  always_comb begin
    next_zc = SWITCH_OUT.autozero_loop ? zc + 10'(PHASE_TICK_OUT) : '0;
    next_ic = SWITCH_OUT.input_connect ? ic + 10'(PHASE_TICK_OUT) : '0;
    next_bc = BUSY_OUT ? bc + 10'(PHASE_TICK_OUT) : '0;
    // ticks since the zeroing phase began
    next_cc = cc + 11'(PHASE_TICK_OUT);
    if (SWITCH_OUT.autozero_loop && !az_q) begin
      next_cc = '0;
    end
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      zc <= '0;
      ic <= '0;
      bc <= '0;
      cc <= '0;
      az_q <= 1'b0;
    end else begin
      zc <= next_zc;
      ic <= next_ic;
      bc <= next_bc;
      cc <= next_cc;
      az_q <= SWITCH_OUT.autozero_loop;
    end
  end
  sequence s_integ_end;
    $fell(SWITCH_OUT.input_connect);
  endsequence
  a_zero_len: assert property ($fell(SWITCH_OUT.autozero_loop) |-> zc == 10'd246)
    else $error("zero phase length wrong");
  a_integ_len: assert property ($fell(SWITCH_OUT.input_connect) |-> ic == 10'd256)
    else $error("integrate length wrong");
  a_busy_len: assert property ($fell(BUSY_OUT) |-> bc == 10'd836)
    else $error("busy length wrong");
  a_conv_len: assert property ($fell(SWITCH_OUT.slow_reference_capacitor) |-> cc == 11'd1280)
    else $error("conversion length wrong");
  a_tick_div: assert property (PHASE_TICK_OUT |=> !PHASE_TICK_OUT [*3])
    else $error("divided tick too close");
  a_zero_sw: assert property (SWITCH_OUT.autozero_loop |-> SWITCH_OUT.short_to_common
    && SWITCH_OUT.neg_to_common && !SWITCH_OUT.input_connect)
    else $error("zeroing switches wrong");
  a_integ_open: assert property (SWITCH_OUT.input_connect
    |-> !SWITCH_OUT.autozero_loop && !SWITCH_OUT.short_to_common)
    else $error("integrate switches wrong");
  a_fast_common: assert property (SWITCH_OUT.fast_reference_capacitor
    |-> SWITCH_OUT.neg_to_common && BUSY_OUT)
    else $error("fast subphase switches wrong");
  a_slow_after: assert property ($rose(SWITCH_OUT.slow_reference_capacitor)
    |-> $past(SWITCH_OUT.fast_reference_capacitor))
    else $error("slow not after fast");
  a_busy_start: assert property (s_integ_end |-> ##[0:1] BUSY_OUT)
    else $error("busy not raised after integrate");
  a_res_hold: assert property (!$fell(BUSY_OUT) |-> $stable(RESULT_OUT))
    else $error("result changed while not ending");
endmodule : mcs_chk
bind mcs_sequencer mcs_chk i_mcs_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .SWITCH_OUT(SWITCH_OUT), .RESULT_OUT(RESULT_OUT), .BUSY_OUT(BUSY_OUT),
  .PHASE_TICK_OUT(PHASE_TICK_OUT));

// ==== verif/mcs_integ_model.sv ====
/* integrator and comparator model: charge in lsb counts.
   assumes the fast reference removes 64 counts a tick. */
`timescale 1ns/1ns
module mcs_integ_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input mcs_pkg::mcs_switch_s sw_in,
  input wire logic positive_in,
  input wire logic [14:0] level_in,
  output logic comparator_out
);
  import mcs_pkg::*;
  int charge;
  logic remain;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) charge <= 0;
    else if (sw_in.input_connect) charge <= int'(level_in);
    else if (tick_in && remain && sw_in.fast_reference_capacitor) charge <= charge - 64;
    else if (tick_in && remain && sw_in.slow_reference_capacitor) charge <= charge - 1;
  end
  assign remain = sw_in.fast_reference_capacitor ? charge >= 64 : charge > 0;
  // negative input inverts the sense of remaining charge
  assign comparator_out = sw_in.input_connect ? positive_in : (remain ~^ positive_in);
endmodule : mcs_integ_model

// ==== verif/test_mcs_sequencer.sv ====
/* self-checking bench: demand and continuous conversions.
   assumes the comparator model above and a random oscillator enable. */
`timescale 1ns/1ns
module test_mcs_sequencer;
  import mcs_pkg::*;
  logic clk = 0, rst_n = 0, osc = 0, mode = 0, sel = 0, start_n = 1, pos = 1, cmp, busy, tick;
  logic pb = 0;
  logic [14:0] lvl = '0;
  mcs_switch_s sw;
  mcs_result_s res, expq[$];
  int num_errors = 0, n_tests = 0, blen = 0;
  mcs_sequencer i_mcs_sequencer (.CLK_IN(clk), .RST_N_IN(rst_n), .OSC_TICK_IN(osc),
    .CONVERSION_MODE_SELECT_IN(mode), .SELECT_IN(sel), .START_N_IN(start_n),
    .COMPARATOR_IN(cmp), .SWITCH_OUT(sw), .RESULT_OUT(res), .BUSY_OUT(busy),
    .PHASE_TICK_OUT(tick));
  mcs_integ_model i_mcs_integ_model (.clk_in(clk), .rst_n_in(rst_n), .tick_in(tick),
    .sw_in(sw), .positive_in(pos), .level_in(lvl), .comparator_out(cmp));
  initial forever #5 clk = ~clk;
  always @(posedge clk) osc <= 1'($urandom_range(0, 1));
  task automatic check_res(input mcs_result_s e, input mcs_result_s g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD result exp %h got %h", e, g);
    end
  endtask : check_res
  task automatic check_len(input int e, input int g);
    n_tests++;
    if (g != e) begin
      num_errors++;
      $display("BAD length exp %0d got %0d", e, g);
    end
  endtask : check_len
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 12000 && busy !== v; i++) @(posedge clk);
  endtask : wait_busy
  task automatic strobe();
    start_n <= 0;
    @(posedge clk);
    start_n <= 1;
    @(posedge clk);
  endtask : strobe
  task automatic load(input logic [14:0] v);
    pos <= 1'($urandom_range(0, 1));
    lvl <= v;
    @(posedge clk);
    expq.push_back({pos, 1'b0, lvl});
  endtask : load
  // result monitor: oldest note against the value at busy fall
  always @(negedge clk) begin
    if (pb && busy === 1'b0) begin
      check_len(836, blen);
      if (expq.size() == 0) check_len(1, 0);
      else check_res(expq.pop_front(), res);
      blen = 0;
    end
    if (busy === 1'b1 && tick === 1'b1) blen++;
    pb = busy;
  end
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'hf605));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    strobe();
    repeat (100) @(posedge clk);
    check_len(0, int'(busy !== 1'b0 || sw.autozero_loop !== 1'b0));
    sel <= 1;
    load(15'($urandom));
    strobe();
    wait_busy(1);
    strobe();
    expq.push_back({pos, 1'b0, lvl});
    wait_busy(0);
    wait_busy(1);
    wait_busy(0);
    load(15'h7fff);
    mode <= 1;
    wait_busy(1);
    wait_busy(0);
    load(15'h0000);
    wait_busy(1);
    mode <= 0;
    wait_busy(0);
    repeat (20) @(posedge clk);
    check_len(0, expq.size());
    close_out();
  end
endmodule : test_mcs_sequencer
